// *** io_consts.svh ***
// Register offsets, field positions, reset values and select codes of the analog/digital output logic
`ifndef IO_CONSTS_SVH
`define IO_CONSTS_SVH

`define REG_SCALE0       8'h00
`define REG_SCALE1       8'h04
`define REG_SCALE2       8'h08
`define REG_OFFSET0      8'h0C
`define REG_OFFSET1      8'h10
`define REG_OFFSET2      8'h14
`define REG_REF0         8'h18
`define REG_REF1         8'h1C
`define REG_REF2         8'h20
`define REG_SEL_RELAY1   8'h24
`define REG_SEL_RELAY2   8'h28
`define REG_SEL_RELAY3   8'h2C
`define REG_SEL_OC       8'h30
`define REG_STATUS       8'h34

`define SEL_FN1_LSB      0
`define SEL_FN2_LSB      8
`define STAT_OUT_LSB     0
`define STAT_OC_IN_LSB   4
`define STAT_PUMP_LSB    5

`define SCALE_RESET      16'sh03E8
`define OFFSET_RESET     16'sh0000
`define SEL_RESET        6'h00
`define PCT_MAX          16'sh1388
`define PCT_MIN          -16'sh1388
`define PCT_DIVISOR      32'sh000003E8
`define SAT_MAX          32'sh00007FFF
`define SAT_MIN          -32'sh00008000

`define FN_NONE          6'h00
`define FN_PLC           6'h3E
`define FN_PUMP          6'h3F

`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// *** io_pkg.sv ***
// Types shared by the analog referencing and digital output logic
package io_pkg;
  typedef logic signed [15:0] pct_t;
  typedef logic [5:0] sel_t;

  typedef struct packed {
    logic            awready;
    logic            wready;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arready;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
    logic            aw_have;
    logic [7:0]      awaddr;
    logic            w_have;
    logic [31:0]     wdata;
    logic [3:0]      wstrb;
    pct_t [2:0]      scale;
    pct_t [2:0]      offset;
    sel_t [3:0]      sel1;
    sel_t [3:0]      sel2;
    logic [3:0]      outs;
    logic            oc_out;
  } top_state_t;

  typedef struct packed {
    pct_t result;
  } unit_state_t;
endpackage

// *** ref_if.sv ***
// Settings and result of one analog referencing unit
`timescale 1ns/1ps
interface ref_if;
  import io_pkg::*;
  pct_t scale;
  pct_t offset;
  pct_t ain;
  logic sample;
  pct_t result;
  modport ctrl (output scale, output offset, output ain, output sample, input result);
  modport unit (input scale, input offset, input ain, input sample, output result);
endinterface

// *** ref_unit.sv ***
// One analog referencing unit: offset plus scaled input, saturated
`timescale 1ns/1ps
`include "io_consts.svh"
module ref_unit (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Settings, input and result
  ref_if.unit       ru
);
  import io_pkg::*;

  unit_state_t       q;
  unit_state_t       n;
  logic signed [31:0] prod;
  logic signed [31:0] sum;

  always_comb begin
    n = q;
    // Tenths times tenths over 1000 gives tenths again
    // Widen both factors first so the product never wraps at 16 bits
    prod = 32'(ru.scale) * 32'(ru.ain);                                // [R2]
    sum  = 32'(ru.offset) + (prod / `PCT_DIVISOR);                     // [R2]
    if (ru.sample) begin                                               // [R11]
      if (sum > `SAT_MAX) begin
        n.result = 16'sh7FFF;                                          // [R11]
      end else if (sum < `SAT_MIN) begin
        n.result = -16'sh8000;                                         // [R11]
      end else begin
        n.result = sum[15:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign ru.result = q.result;
endmodule

// *** io_logic.sv ***
// Analog referencing units and digital output function routing behind an AXI4-Lite slave
// Notes on behaviour
// [R1] Each referencing unit has a signed scale and offset in tenths of a percent, limited to -500.0 to 500.0 percent.
// [R2] Each unit computes offset plus scale times its own analog input divided by 100.0 percent.
// [R3] Each unit result is readable and writes to it are ignored.
// [R4] There are four digital outputs: three relays and one open-collector transistor.
// [R5] Every digital output has two independent function selections.
// [R6] A digital output is active when either selected function is active and inactive only when both are inactive.
// [R7] A selection code hands the output to the built-in PLC.
// [R8] In pump-group control a selection code drives the pump contactor signal onto the output.
// [R9] Unit results are offered as ports to the PID controller, PLC and control structure.
// [R10] Analog input readings arrive as tenths of a percent of their range, so half span reads 500.
// [R11] Arithmetic is signed fixed point in tenths, saturated, and refreshed on every input sample.
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "io_consts.svh"
module io_logic #(
  parameter int NUM_FUNC = 62
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Analog input readings
  input  wire io_pkg::pct_t          analog_input_0,
  input  wire io_pkg::pct_t          analog_input_1,
  input  wire io_pkg::pct_t          analog_input_2,
  input  wire logic                  analog_sample,
  // Referencing results
  output io_pkg::pct_t               analog_reference_0,
  output io_pkg::pct_t               analog_reference_1,
  output io_pkg::pct_t               analog_reference_2,
  // Function sources
  input  wire logic [NUM_FUNC-1:0]   function_signals,
  input  wire logic [3:0]            plc_outputs,
  input  wire logic [3:0]            pump_contactors,
  input  wire logic                  pump_mode,
  // Digital outputs
  output logic                       relay_output_1,
  output logic                       relay_output_2,
  output logic                       relay_output_3,
  output logic                       open_collector_output,
  output logic                       open_collector_oe,
  input  wire logic                  open_collector_in
);
  import io_pkg::*;

  top_state_t      q;
  top_state_t      n;
  pct_t [2:0]      ref_val;
  pct_t [2:0]      ain;
  logic [63:0]     fn_vec;
  logic [31:0]     rd;
  logic            rd_ok;
  logic            wr_ok;
  logic [31:0]     wmerged;
  pct_t            wval;
  logic [1:0]      widx;

  ref_if ru[3] ();

  assign ain = {analog_input_2, analog_input_1, analog_input_0};

  generate
    for (genvar i = 0; i < 3; i++) begin : g_ref
      assign ru[i].scale  = q.scale[i];
      assign ru[i].offset = q.offset[i];
      assign ru[i].ain    = ain[i];                                    // [R10]
      assign ru[i].sample = analog_sample;                             // [R11]
      assign ref_val[i]   = ru[i].result;
      ref_unit u_ref (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ru      (ru[i])
      );
    end
  endgenerate

  // Unused codes read as inactive; the top two codes are claimed by PLC and pump
  assign fn_vec = 64'({function_signals, 1'b0});

  function automatic pct_t clamp_pct(input pct_t v);
    if (v > `PCT_MAX) begin
      return `PCT_MAX;                                                 // [R1]
    end else if (v < `PCT_MIN) begin
      return `PCT_MIN;                                                 // [R1]
    end
    return v;
  endfunction

  function automatic logic pick(input sel_t s, input logic plc, input logic pump, input logic [63:0] fv,
                                input logic pmode);
    if (s == `FN_PLC) begin
      return plc;                                                      // [R7]
    end else if (s == `FN_PUMP) begin
      return pump & pmode;                                             // [R8]
    end
    return fv[s];
  endfunction

  always_comb begin
    rd_ok = 1'b1;
    rd    = 32'h0000_0000;
    case (s_axi_araddr)
      `REG_SCALE0, `REG_SCALE1, `REG_SCALE2:
        rd = {16'h0000, q.scale[2'(s_axi_araddr[7:2])]};
      `REG_OFFSET0, `REG_OFFSET1, `REG_OFFSET2:
        rd = {16'h0000, q.offset[2'(s_axi_araddr[7:2] - 6'h03)]};
      `REG_REF0, `REG_REF1, `REG_REF2:
        rd = {16'h0000, ref_val[2'(s_axi_araddr[7:2] - 6'h06)]};       // [R3]
      `REG_SEL_RELAY1, `REG_SEL_RELAY2, `REG_SEL_RELAY3, `REG_SEL_OC: begin
        rd[`SEL_FN1_LSB +: 6] = q.sel1[2'(s_axi_araddr[7:2] - 6'h09)];
        rd[`SEL_FN2_LSB +: 6] = q.sel2[2'(s_axi_araddr[7:2] - 6'h09)];
      end
      `REG_STATUS: begin
        rd[`STAT_OUT_LSB +: 4] = q.outs;
        rd[`STAT_OC_IN_LSB]    = open_collector_in;
        rd[`STAT_PUMP_LSB]     = pump_mode;
      end
      default:
        rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    n = q;
    wr_ok = 1'b1;
    widx  = 2'b00;
    for (int b = 0; b < 4; b++) begin
      wmerged[b*8 +: 8] = q.wstrb[b] ? q.wdata[b*8 +: 8] : 8'h00;
    end
    wval = clamp_pct(wmerged[15:0]);
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
    if (s_axi_awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.awaddr  = s_axi_awaddr;
      n.awready = 1'b0;
    end
    if (s_axi_wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
      n.wready = 1'b0;
    end
    if (q.aw_have && q.w_have && !q.bvalid) begin
      case (q.awaddr)
        `REG_SCALE0, `REG_SCALE1, `REG_SCALE2: begin
          widx = 2'(q.awaddr[7:2]);
          if (q.wstrb[1:0] == 2'b11) begin
            n.scale[widx] = wval;                                      // [R1]
          end
        end
        `REG_OFFSET0, `REG_OFFSET1, `REG_OFFSET2: begin
          widx = 2'(q.awaddr[7:2] - 6'h03);
          if (q.wstrb[1:0] == 2'b11) begin
            n.offset[widx] = wval;                                     // [R1]
          end
        end
        // Results and status are read only; the write is answered OKAY and dropped
        `REG_REF0, `REG_REF1, `REG_REF2, `REG_STATUS: ;                // [R3]
        `REG_SEL_RELAY1, `REG_SEL_RELAY2, `REG_SEL_RELAY3, `REG_SEL_OC: begin
          widx = 2'(q.awaddr[7:2] - 6'h09);
          if (q.wstrb[0]) begin
            n.sel1[widx] = wmerged[`SEL_FN1_LSB +: 6];                 // [R5]
          end
          if (q.wstrb[1]) begin
            n.sel2[widx] = wmerged[`SEL_FN2_LSB +: 6];                 // [R5]
          end
        end
        default:
          wr_ok = 1'b0;
      endcase
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
      n.awready = 1'b1;
      n.wready  = 1'b1;
      n.bvalid  = 1'b1;
      n.bresp   = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (s_axi_arvalid && q.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rdata   = rd;
      n.rresp   = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    for (int k = 0; k < 4; k++) begin
      n.outs[k] = pick(q.sel1[k], plc_outputs[k], pump_contactors[k], fn_vec, pump_mode)
                | pick(q.sel2[k], plc_outputs[k], pump_contactors[k], fn_vec, pump_mode);  // [R6]
    end
    // Open collector only ever sinks, so its data level stays low
    n.oc_out = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
      q.scale   <= {`SCALE_RESET, `SCALE_RESET, `SCALE_RESET};
      q.offset  <= {`OFFSET_RESET, `OFFSET_RESET, `OFFSET_RESET};
      q.sel1    <= {4{`SEL_RESET}};
      q.sel2    <= {4{`SEL_RESET}};
    end else begin
      q <= n;
    end
  end

  assign s_axi_awready         = q.awready;
  assign s_axi_wready          = q.wready;
  assign s_axi_bvalid          = q.bvalid;
  assign s_axi_bresp           = q.bresp;
  assign s_axi_arready         = q.arready;
  assign s_axi_rvalid          = q.rvalid;
  assign s_axi_rresp           = q.rresp;
  assign s_axi_rdata           = q.rdata;
  assign analog_reference_0    = ref_val[0];                           // [R9]
  assign analog_reference_1    = ref_val[1];                           // [R9]
  assign analog_reference_2    = ref_val[2];                           // [R9]
  assign relay_output_1        = q.outs[0];                            // [R4]
  assign relay_output_2        = q.outs[1];                            // [R4]
  assign relay_output_3        = q.outs[2];                            // [R4]
  assign open_collector_output = q.oc_out;
  assign open_collector_oe     = q.outs[3];                            // [R4]
endmodule

// *** io_logic_assertions.sv ***
// Port-level concurrent checks for the analog referencing and digital output logic
`timescale 1ns/1ps
module io_logic_assertions #(
  parameter int NUM_FUNC = 62
) (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Bus handshakes
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  // Referencing units
  input wire logic                analog_sample,
  input wire io_pkg::pct_t        analog_reference_0,
  input wire io_pkg::pct_t        analog_reference_1,
  input wire io_pkg::pct_t        analog_reference_2,
  // Function sources and outputs
  input wire logic [NUM_FUNC-1:0] function_signals,
  input wire logic [3:0]          plc_outputs,
  input wire logic [3:0]          pump_contactors,
  input wire logic                pump_mode,
  input wire logic                relay_output_1,
  input wire logic                relay_output_2,
  input wire logic                relay_output_3,
  input wire logic                open_collector_output,
  input wire logic                open_collector_oe
);
  wire logic [3:0] outs = {open_collector_oe, relay_output_3, relay_output_2, relay_output_1};
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_OC_LOW: assert property (open_collector_output == 1'b0)
    else $error("open collector level driven");
  AST_IDLE_OUTS: assert property (~|function_signals && plc_outputs == 4'h0 && pump_contactors == 4'h0
    |=> outs == 4'h0) else $error("output active with no source");
  AST_PUMP_GATE: assert property (~|function_signals && plc_outputs == 4'h0 && !pump_mode
    |=> outs == 4'h0) else $error("pump contactor passed with pump mode off");
  AST_REF_HOLD: assert property (!analog_sample
    |=> $stable({analog_reference_0, analog_reference_1, analog_reference_2})) else $error("result moved");
  AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  AST_B_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not closed");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during data phase");
endmodule
bind io_logic io_logic_assertions #(.NUM_FUNC(NUM_FUNC)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_sample(analog_sample),
  .analog_reference_0(analog_reference_0), .analog_reference_1(analog_reference_1),
  .analog_reference_2(analog_reference_2), .function_signals(function_signals), .plc_outputs(plc_outputs),
  .pump_contactors(pump_contactors), .pump_mode(pump_mode), .relay_output_1(relay_output_1),
  .relay_output_2(relay_output_2), .relay_output_3(relay_output_3),
  .open_collector_output(open_collector_output), .open_collector_oe(open_collector_oe));

// *** io_front.sv ***
// Model of the analog front end and the open-collector pin around the logic
`timescale 1ns/1ps
module io_front (
  // Clock
  input  wire logic    aclk,
  // Analog readings
  output io_pkg::pct_t analog_input_0,
  output io_pkg::pct_t analog_input_1,
  output io_pkg::pct_t analog_input_2,
  output logic         analog_sample,
  // Open-collector pin
  input  wire logic    open_collector_oe,
  output logic         open_collector_in
);
  import io_pkg::*;
  // Pull-up holds the pin high; the transistor sinks it while enabled
  assign open_collector_in = !open_collector_oe;
  initial begin
    analog_input_0 = 16'sh0000;
    analog_input_1 = 16'sh0000;
    analog_input_2 = 16'sh0000;
    analog_sample = 1'b0;
  end
  // One conversion in tenths of a percent; the strobe lasts one cycle only
  task automatic convert(input pct_t a0, input pct_t a1, input pct_t a2);
    @(posedge aclk);
    analog_input_0 <= a0;
    analog_input_1 <= a1;
    analog_input_2 <= a2;
    analog_sample <= 1'b1;
    @(posedge aclk);
    analog_sample <= 1'b0;
  endtask
endmodule

// *** testbench.sv ***
// Self-checking bench for the analog referencing and digital output logic
`timescale 1ns/1ps
`include "io_consts.svh"
module testbench;
  import io_pkg::*;
  localparam int NF = 62;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]   wdata = 32'h0, rdata;
  logic [3:0]    wstrb = 4'h0, plc = 4'h0, pump = 4'h0, e;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid, smp, r1, r2, r3, oc_out, oc_oe, oc_in;
  logic          pump_mode = 1'b0;
  logic [1:0]    bresp, rresp;
  logic [NF-1:0] fsig = '0, v;
  pct_t          ain0, ain1, ain2, ref0, ref1, ref2;
  int            num_errors = 0, n_checks = 0, c;
  int            sc[3], of[3], ai[3], f1[4], f2[4], pl[3], pu[3], md[3], ex[3];
  wire logic [3:0] outs = {oc_oe, r3, r2, r1};
  always #4 aclk = ~aclk;
  io_logic #(.NUM_FUNC(NF)) u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .analog_input_0(ain0), .analog_input_1(ain1), .analog_input_2(ain2),
    .analog_sample(smp), .analog_reference_0(ref0), .analog_reference_1(ref1), .analog_reference_2(ref2),
    .function_signals(fsig), .plc_outputs(plc), .pump_contactors(pump), .pump_mode(pump_mode),
    .relay_output_1(r1), .relay_output_2(r2), .relay_output_3(r3), .open_collector_output(oc_out),
    .open_collector_oe(oc_oe), .open_collector_in(oc_in));
  io_front u_fe (.aclk(aclk), .analog_input_0(ain0), .analog_input_1(ain1), .analog_input_2(ain2),
    .analog_sample(smp), .open_collector_oe(oc_oe), .open_collector_in(oc_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] time %0t got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk({30'h0, rresp}, {30'h0, er});
    if (er == `RESP_OKAY) chk(rdata, ed);
  endtask
  // Truncating division and 16-bit saturation, as the unit must behave
  function automatic logic [15:0] ref_exp(input int s, input int o, input int a);
    int r;
    r = o + (s * a) / 1000;
    if (r > 32767) r = 32767;
    if (r < -32768) r = -32768;
    return r[15:0];
  endfunction
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A few hundred cycles are expected; the margin covers slow handshakes
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    sc = '{500, 333, -700};
    of = '{200, -100, 3000};
    ai = '{500, -250, 1000};
    f1 = '{1, 3, 5, 7};
    f2 = '{2, 4, 6, 61};
    pl = '{0, 5, 5};
    pu = '{3, 0, 3};
    md = '{0, 0, 1};
    ex = '{0, 5, 7};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      rd(`REG_SCALE0 + 8'(4 * k), 32'h0000_03E8, `RESP_OKAY);
      rd(`REG_OFFSET0 + 8'(4 * k), 32'h0, `RESP_OKAY);
      rd(`REG_REF0 + 8'(4 * k), 32'h0, `RESP_OKAY);
    end
    rd(8'h38, 32'h0, `RESP_SLVERR);
    wr(8'h38, 32'h1, 4'hF, `RESP_SLVERR);
    rd(`REG_STATUS, 32'h0000_0010, `RESP_OKAY);
    $display("test 1 done");
    for (int k = 0; k < 3; k++) begin
      wr(`REG_SCALE0 + 8'(4 * k), 32'(sc[k]), 4'h3, `RESP_OKAY);
      wr(`REG_OFFSET0 + 8'(4 * k), 32'(of[k]), 4'h3, `RESP_OKAY);
    end
    u_fe.convert(16'(ai[0]), 16'(ai[1]), 16'(ai[2]));
    @(posedge aclk);
    chk({ref2, ref1}, {ref_exp(sc[2], of[2], ai[2]), ref_exp(sc[1], of[1], ai[1])});
    chk({16'h0, ref0}, {16'h0, ref_exp(sc[0], of[0], ai[0])});
    for (int k = 0; k < 3; k++) begin
      rd(`REG_REF0 + 8'(4 * k), {16'h0, ref_exp(sc[k], of[k], ai[k])}, `RESP_OKAY);
    end
    $display("test 2 done");
    wr(`REG_SCALE0, 32'(6000), 4'h3, `RESP_OKAY);
    wr(`REG_OFFSET0, 32'(-6000), 4'h3, `RESP_OKAY);
    wr(`REG_SCALE1, 32'h7, 4'h1, `RESP_OKAY);
    rd(`REG_SCALE0, 32'h0000_1388, `RESP_OKAY);
    rd(`REG_OFFSET0, 32'h0000_EC78, `RESP_OKAY);
    rd(`REG_SCALE1, 32'h0000_014D, `RESP_OKAY);
    for (int j = 0; j < 2; j++) begin
      c = (j == 0) ? 32767 : -32768;
      u_fe.convert(16'(c), 16'(ai[1]), 16'(ai[2]));
      @(posedge aclk);
      chk({16'h0, ref0}, {16'h0, ref_exp(5000, -5000, c)});
    end
    wr(`REG_REF0, 32'h1234, 4'hF, `RESP_OKAY);
    rd(`REG_REF0, 32'h0000_8000, `RESP_OKAY);
    $display("test 3 done");
    for (int k = 0; k < 4; k++) begin
      wr(`REG_SEL_RELAY1 + 8'(4 * k), {18'h0, 6'(f2[k]), 2'b00, 6'(f1[k])}, 4'h3, `RESP_OKAY);
    end
    for (int i = 0; i < 4; i++) begin
      v = '0;
      for (int k = 0; k < 4; k++) begin
        c = (i + k) % 4;
        v[f1[k] - 1] = c[0];
        v[f2[k] - 1] = c[1];
        e[k] = (c != 0);
      end
      @(posedge aclk);
      fsig <= v;
      repeat (2) @(posedge aclk);
      chk({28'h0, outs}, {28'h0, e});
    end
    rd(`REG_STATUS, 32'h0000_000D, `RESP_OKAY);
    $display("test 4 done");
    for (int k = 0; k < 4; k++) begin
      wr(`REG_SEL_RELAY1 + 8'(4 * k), {18'h0, `FN_PUMP, 2'b00, `FN_PLC}, 4'h3, `RESP_OKAY);
    end
    @(posedge aclk);
    fsig <= '0;
    for (int j = 0; j < 3; j++) begin
      @(posedge aclk);
      plc <= 4'(pl[j]);
      pump <= 4'(pu[j]);
      pump_mode <= md[j][0];
      repeat (2) @(posedge aclk);
      chk({28'h0, outs}, 32'(ex[j]));
      chk({31'h0, oc_out}, 32'h0);
    end
    rd(`REG_STATUS, 32'h0000_0037, `RESP_OKAY);
    $display("test 5 done");
    stop_test();
  end
endmodule
